// ---- rtl/pvt_video_source.sv ----
// parallel RGB video source with AHB-Lite control and device configuration port
// Behaviour
// - frame sync high at least one line
// - two lines frame sync to first active
// - one line last active to frame sync
// - back plus front porch at least twelve
// - line sync high 4 to 128 clocks
// - four clocks line sync to data valid
// - eight clocks data valid end to sync
// - delay setting kept within porch-derived bounds
// - line length is ceiling of clock/rate
// - too little blanking refuses to run
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module pvt_video_source (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic pclk,
   output pvt_pkg::pvt_video_type video,
   output pvt_pkg::pvt_cfg_type cfg,
   input wire logic cfg_ready
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic enable, next_enable;
   logic cap_fall, next_cap_fall;
   logic cfg_go, next_cfg_go;
   logic [7:0] hsw, next_hsw;
   logic [7:0] hbp, next_hbp;
   logic [15:0] h_act, next_h_act;
   logic [7:0] vsw, next_vsw;
   logic [7:0] vbp, next_vbp;
   logic [7:0] vfp, next_vfp;
   logic [15:0] v_act, next_v_act;
   logic [3:0] half_div, next_half_div;
   logic [15:0] line_rate, next_line_rate;
   logic [7:0] delay, next_delay;
   logic [pvt_pkg::PIXEL_W-1:0] color, next_color;
   logic wr_pend, next_wr_pend;
   logic [7:0] wr_addr, next_wr_addr;
   logic [31:0] next_hrdata;

   // ----------------------------------------------------------------
   // video and configuration state
   // ----------------------------------------------------------------
   pvt_pkg::pvt_state_type state, next_state;
   logic [15:0] h_cnt, next_h_cnt;
   logic [15:0] v_cnt, next_v_cnt;
   logic [15:0] frames, next_frames;
   pvt_pkg::pvt_video_type next_video;
   pvt_pkg::pvt_cfg_type next_cfg;
   logic [15:0] line_total;
   logic timing_ok;
   logic delay_ok;
   logic launch;
   logic running;
   logic [15:0] v_total;
   logic last_h;
   logic last_v;

   assign running = state == pvt_pkg::PVT_RUN;
   assign v_total = 16'(vbp) + v_act + 16'(vfp);
   assign last_h = h_cnt >= line_total - 16'h1;
   assign last_v = v_cnt >= v_total - 16'h1;

   pvt_timing_check u_check (
      .hsw(hsw),
      .hbp(hbp),
      .h_act(h_act),
      .vsw(vsw),
      .vbp(vbp),
      .vfp(vfp),
      .v_act(v_act),
      .half_div(half_div),
      .line_rate(line_rate),
      .delay(delay),
      .line_total(line_total),
      .timing_ok(timing_ok),
      .delay_ok(delay_ok)
   );

   pvt_pclk_gen u_pclk (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .run(running),
      .half_div(half_div),
      .capture_falling(cap_fall),
      .pclk(pclk),
      .launch(launch)
   );

   // ----------------------------------------------------------------
   // bus slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   always_comb begin
      next_enable = enable;
      next_cap_fall = cap_fall;
      next_cfg_go = 1'b0;
      next_hsw = hsw;
      next_hbp = hbp;
      next_h_act = h_act;
      next_vsw = vsw;
      next_vbp = vbp;
      next_vfp = vfp;
      next_v_act = v_act;
      next_half_div = half_div;
      next_line_rate = line_rate;
      next_delay = delay;
      next_color = color;
      next_hrdata = 32'h0;
      next_wr_pend = hsel && hready && htrans[1] && hwrite;
      next_wr_addr = haddr[7:0];
      if (wr_pend) begin
         unique case (wr_addr)
            pvt_pkg::REG_CTRL: begin
               next_enable = hwdata[pvt_pkg::CTRL_EN];
               // edge choice is frozen while running so the launch edge never moves
               if (!running) begin
                  next_cap_fall = hwdata[pvt_pkg::CTRL_FALL];
               end
               next_cfg_go = hwdata[pvt_pkg::CTRL_CFG];
            end
            pvt_pkg::REG_HTIME: begin
               next_hsw = hwdata[pvt_pkg::F0 +: 8];
               next_hbp = hwdata[pvt_pkg::F1 +: 8];
               next_h_act = hwdata[pvt_pkg::F2 +: 16];
            end
            pvt_pkg::REG_VTIME: begin
               next_vsw = hwdata[pvt_pkg::F0 +: 8];
               next_vbp = hwdata[pvt_pkg::F1 +: 8];
               next_vfp = hwdata[pvt_pkg::F2 +: 8];
            end
            pvt_pkg::REG_VACT: begin
               next_v_act = hwdata[pvt_pkg::F0 +: 16];
               next_half_div = hwdata[pvt_pkg::F2 +: 4];
            end
            pvt_pkg::REG_LRATE: next_line_rate = hwdata[pvt_pkg::F0 +: 16];
            pvt_pkg::REG_DELAY: next_delay = hwdata[pvt_pkg::F0 +: 8];
            pvt_pkg::REG_COLOR: next_color = hwdata[pvt_pkg::PIXEL_W-1:0];
            default: begin
            end
         endcase
      end
      if (hsel && hready && htrans[1] && !hwrite) begin
         unique case (haddr[7:0])
            pvt_pkg::REG_CTRL: next_hrdata = {29'h0, 1'b0, cap_fall, enable};
            pvt_pkg::REG_STATUS: begin
               next_hrdata[pvt_pkg::ST_RUN] = running;
               next_hrdata[pvt_pkg::ST_TERR] = !timing_ok;
               next_hrdata[pvt_pkg::ST_DERR] = !delay_ok;
               next_hrdata[pvt_pkg::ST_CBUSY] = cfg.valid;
               next_hrdata[pvt_pkg::ST_FRAMES +: 16] = frames;
            end
            pvt_pkg::REG_HTIME: next_hrdata = {h_act, hbp, hsw};
            pvt_pkg::REG_VTIME: next_hrdata = {8'h0, vfp, vbp, vsw};
            pvt_pkg::REG_VACT: next_hrdata = {12'h0, half_div, v_act};
            pvt_pkg::REG_LRATE: next_hrdata = {16'h0, line_rate};
            pvt_pkg::REG_DELAY: next_hrdata = {24'h0, delay};
            pvt_pkg::REG_COLOR: next_hrdata = {8'h0, color};
            default: next_hrdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         enable <= 1'b0;
         cap_fall <= 1'b0;
         cfg_go <= 1'b0;
         hsw <= pvt_pkg::HSW_RESET;
         hbp <= pvt_pkg::HBP_RESET;
         h_act <= pvt_pkg::HACT_RESET;
         vsw <= pvt_pkg::VSW_RESET;
         vbp <= pvt_pkg::VBP_RESET;
         vfp <= pvt_pkg::VFP_RESET;
         v_act <= pvt_pkg::VACT_RESET;
         half_div <= pvt_pkg::DIV_RESET;
         line_rate <= pvt_pkg::LRATE_RESET;
         // shadow matches the device's own reset value of the setting
         delay <= pvt_pkg::DELAY_RESET;
         color <= '0;
         wr_pend <= 1'b0;
         wr_addr <= 8'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         enable <= next_enable;
         cap_fall <= next_cap_fall;
         cfg_go <= next_cfg_go;
         hsw <= next_hsw;
         hbp <= next_hbp;
         h_act <= next_h_act;
         vsw <= next_vsw;
         vbp <= next_vbp;
         vfp <= next_vfp;
         v_act <= next_v_act;
         half_div <= next_half_div;
         line_rate <= next_line_rate;
         delay <= next_delay;
         color <= next_color;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // device configuration write of the frame-sync line delay
   // ----------------------------------------------------------------
   always_comb begin
      next_cfg = cfg;
      if (cfg.valid && cfg_ready) begin
         next_cfg.valid = 1'b0;
      end else if (!cfg.valid && cfg_go && delay_ok) begin
         // an out-of-range setting is never sent to the device
         next_cfg.valid = 1'b1;
         next_cfg.addr = pvt_pkg::CFG_ADDR_DELAY;
         next_cfg.data = delay;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg <= '0;
      end else begin
         cfg <= next_cfg;
      end
   end

   // ----------------------------------------------------------------
   // frame timing generator, advanced once per pixel clock
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_h_cnt = h_cnt;
      next_v_cnt = v_cnt;
      next_frames = frames;
      next_video = video;
      unique case (state)
         pvt_pkg::PVT_IDLE: begin
            next_video = '0;
            next_h_cnt = 16'h0;
            next_v_cnt = 16'h0;
            // illegal timing or delay keeps the source silent
            if (enable && timing_ok && delay_ok && !cfg.valid) begin
               next_state = pvt_pkg::PVT_RUN;
            end
         end
         pvt_pkg::PVT_RUN: begin
            if (launch) begin
               next_video.frame_sync = v_cnt < 16'(vsw);
               next_video.line_sync = h_cnt < 16'(hsw);
               // active window opens hbp clocks after line sync, vbp lines after frame sync
               next_video.active_data_valid = h_cnt >= 16'(hbp)
                  && h_cnt < 16'(hbp) + h_act
                  && v_cnt >= 16'(vbp) && v_cnt < 16'(vbp) + v_act;
               next_video.pixel_bus = next_video.active_data_valid ? color : '0;
               if (last_h) begin
                  next_h_cnt = 16'h0;
                  next_v_cnt = last_v ? 16'h0 : v_cnt + 16'h1;
               end else begin
                  next_h_cnt = h_cnt + 16'h1;
               end
               // stop only at a frame boundary so no frame is cut short
               if (last_h && last_v) begin
                  next_frames = frames + 16'h1;
                  if (!enable || !timing_ok || !delay_ok) begin
                     next_state = pvt_pkg::PVT_IDLE;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= pvt_pkg::PVT_IDLE;
         h_cnt <= 16'h0;
         v_cnt <= 16'h0;
         frames <= 16'h0;
         video <= '0;
      end else begin
         state <= next_state;
         h_cnt <= next_h_cnt;
         v_cnt <= next_v_cnt;
         frames <= next_frames;
         video <= next_video;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/pvt_pkg.sv ----
// shared constants, register map and carrier types of the parallel video source
package pvt_pkg;
   // ----------------------------------------------------------------
   // clock and pixel clock limits
   // ----------------------------------------------------------------
   localparam int SYS_CLK_NS = 100;
   localparam int SYS_CLK_KHZ = 1000000 / SYS_CLK_NS;
   localparam int PCLK_MIN_KHZ = 1000;
   localparam int PCLK_MAX_KHZ = 33500;
   localparam int PIXEL_W = 24;

   // ----------------------------------------------------------------
   // frame and line timing limits, in lines and pixel clocks
   // ----------------------------------------------------------------
   localparam logic [7:0] VSW_MIN = 8'h01;
   localparam logic [7:0] VBP_MIN = 8'h02;
   localparam logic [7:0] VFP_MIN = 8'h01;
   localparam logic [8:0] VBLANK_MIN = 9'h00C;
   localparam logic [7:0] HSW_MIN = 8'h04;
   localparam logic [8:0] HSW_MAX = 9'h080;
   localparam logic [7:0] HBP_MIN = 8'h04;
   localparam logic [7:0] HFP_MIN = 8'h08;

   // ----------------------------------------------------------------
   // device frame-sync line delay setting
   // ----------------------------------------------------------------
   localparam logic [7:0] CFG_ADDR_DELAY = 8'h23;
   localparam logic [7:0] DELAY_RESET = 8'h05;
   localparam logic [7:0] DELAY_FP_REF = 8'h06;
   localparam logic [7:0] DELAY_BP_SUB = 8'h02;
   localparam logic [7:0] DELAY_MAX = 8'h0F;

   // ----------------------------------------------------------------
   // own register map, byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_HTIME = 8'h08;
   localparam logic [7:0] REG_VTIME = 8'h0C;
   localparam logic [7:0] REG_VACT = 8'h10;
   localparam logic [7:0] REG_LRATE = 8'h14;
   localparam logic [7:0] REG_DELAY = 8'h18;
   localparam logic [7:0] REG_COLOR = 8'h1C;

   localparam int CTRL_EN = 0;
   localparam int CTRL_FALL = 1;
   localparam int CTRL_CFG = 2;
   localparam int ST_RUN = 0;
   localparam int ST_TERR = 1;
   localparam int ST_DERR = 2;
   localparam int ST_CBUSY = 3;
   localparam int ST_FRAMES = 16;
   localparam int F0 = 0;
   localparam int F1 = 8;
   localparam int F2 = 16;

   localparam logic [7:0] HSW_RESET = 8'h08;
   localparam logic [7:0] HBP_RESET = 8'h10;
   localparam logic [15:0] HACT_RESET = 16'h0140;
   localparam logic [7:0] VSW_RESET = 8'h02;
   localparam logic [7:0] VBP_RESET = 8'h08;
   localparam logic [7:0] VFP_RESET = 8'h04;
   localparam logic [15:0] VACT_RESET = 16'h00F0;
   localparam logic [3:0] DIV_RESET = 4'h2;
   localparam logic [15:0] LRATE_RESET = 16'h0011;

   // ----------------------------------------------------------------
   // carriers and states
   // ----------------------------------------------------------------
   typedef struct packed {
      logic frame_sync;
      logic line_sync;
      logic active_data_valid;
      logic [PIXEL_W-1:0] pixel_bus;
   } pvt_video_type;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } pvt_cfg_type;

   typedef enum logic [1:0] {
      PVT_IDLE = 2'b01,
      PVT_RUN = 2'b10
   } pvt_state_type;
endpackage

// ---- rtl/pvt_pclk_gen.sv ----
// pixel clock divider with a launch pulse on the edge opposite the capture edge
`timescale 1ns/100ps
`default_nettype none
module pvt_pclk_gen (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [3:0] half_div,
   input wire logic capture_falling,
   output logic pclk,
   output logic launch
);
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic next_pclk;
   logic next_launch;

   always_comb begin
      next_cnt = cnt;
      next_pclk = pclk;
      next_launch = 1'b0;
      if (!run) begin
         // parked low so that the clock stands still while the source is idle
         next_cnt = 4'h0;
         next_pclk = 1'b0;
      end else if (cnt >= half_div - 4'h1) begin
         next_cnt = 4'h0;
         next_pclk = !pclk;
         // data changes away from the capture edge, half a period of setup
         next_launch = (!pclk) == capture_falling;
      end else begin
         next_cnt = cnt + 4'h1;
      end
   end

   // unregistered so video moves on the launch toggle itself, even at half_div 1
   assign launch = next_launch;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 4'h0;
         pclk <= 1'b0;
      end else begin
         cnt <= next_cnt;
         pclk <= next_pclk;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/pvt_timing_check.sv ----
// combinational legality check of programmed frame timing and delay setting
`timescale 1ns/100ps
`default_nettype none
module pvt_timing_check (
   input wire logic [7:0] hsw,
   input wire logic [7:0] hbp,
   input wire logic [15:0] h_act,
   input wire logic [7:0] vsw,
   input wire logic [7:0] vbp,
   input wire logic [7:0] vfp,
   input wire logic [15:0] v_act,
   input wire logic [3:0] half_div,
   input wire logic [15:0] line_rate,
   input wire logic [7:0] delay,
   output logic [15:0] line_total,
   output logic timing_ok,
   output logic delay_ok
);
   logic [31:0] pclk_khz;
   logic [31:0] total;
   logic [7:0] delay_lo;
   logic [7:0] delay_hi;
   logic h_ok;
   logic v_ok;

   always_comb begin
      pclk_khz = 32'h0;
      total = 32'h0;
      if (half_div != 4'h0 && line_rate != 16'h0) begin
         pclk_khz = 32'(pvt_pkg::SYS_CLK_KHZ) / {27'h0, half_div, 1'b0};
         total = (pclk_khz + {16'h0, line_rate} - 32'h1) / {16'h0, line_rate};
      end
      line_total = total[15:0];
      h_ok = {1'b0, hsw} >= {1'b0, pvt_pkg::HSW_MIN} && {1'b0, hsw} <= pvt_pkg::HSW_MAX
         && hbp >= pvt_pkg::HBP_MIN && hsw <= hbp
         && h_act != 16'h0 && total[31:16] == 16'h0
         // blanking must cover both porches, else the clock or line rate is wrong
         && total >= 32'(h_act) + 32'(hbp) + 32'(pvt_pkg::HFP_MIN);
      v_ok = vsw >= pvt_pkg::VSW_MIN && vsw <= vbp
         && vbp >= pvt_pkg::VBP_MIN
         && vfp >= pvt_pkg::VFP_MIN
         && ({1'b0, vbp} + {1'b0, vfp}) >= pvt_pkg::VBLANK_MIN
         && v_act != 16'h0;
      timing_ok = h_ok && v_ok && half_div != 4'h0 && line_rate != 16'h0
         && pclk_khz >= 32'(pvt_pkg::PCLK_MIN_KHZ) && pclk_khz <= 32'(pvt_pkg::PCLK_MAX_KHZ);
      delay_lo = (vfp >= pvt_pkg::DELAY_FP_REF) ? 8'h00 : pvt_pkg::DELAY_FP_REF - vfp;
      delay_hi = vbp - pvt_pkg::DELAY_BP_SUB;
      if (delay_hi > pvt_pkg::DELAY_MAX) begin
         delay_hi = pvt_pkg::DELAY_MAX;
      end
      delay_ok = vbp >= pvt_pkg::DELAY_BP_SUB && delay >= delay_lo && delay <= delay_hi;
   end
endmodule
`default_nettype wire

// ---- test/pvt_video_source_properties.sv ----
// checker of the video source ports: frame timing, config handshake and launch edge
`timescale 1ns/100ps
`default_nettype none
module pvt_video_source_properties (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic pclk,
   input wire pvt_pkg::pvt_video_type video,
   input wire pvt_pkg::pvt_cfg_type cfg,
   input wire logic cfg_ready
);
   // ------------------------------------------------------------
   // counts in pclk toggles and lines; saturating so idle gaps pass
   // ------------------------------------------------------------
   logic pclk_q, ls_q, fs_q, dv_q, tog, ls_up, dv_dn;
   logic [8:0] hcnt, next_hcnt;
   logic [7:0] fcnt, lcnt, vcnt, next_fcnt, next_lcnt, next_vcnt;
   always_comb begin
      tog = pclk != pclk_q;
      ls_up = video.line_sync && !ls_q;
      dv_dn = dv_q && !video.active_data_valid;
      next_hcnt = ls_up ? '0 : (tog && !(&hcnt)) ? hcnt + 9'h001 : hcnt;
      next_fcnt = dv_dn ? '0 : (tog && !(&fcnt)) ? fcnt + 8'h01 : fcnt;
      next_vcnt = dv_dn ? '0 : (ls_up && !(&vcnt)) ? vcnt + 8'h01 : vcnt;
      next_lcnt = (video.frame_sync && !fs_q) ? '0 : (ls_up && !(&lcnt)) ? lcnt + 8'h01 : lcnt;
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         {pclk_q, ls_q, fs_q, dv_q} <= '0;
         {hcnt, fcnt, lcnt, vcnt} <= '1;
      end else begin
         {pclk_q, ls_q, fs_q} <= {pclk, video.line_sync, video.frame_sync};
         dv_q <= video.active_data_valid;
         {hcnt, fcnt, lcnt, vcnt} <= {next_hcnt, next_fcnt, next_lcnt, next_vcnt};
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_sync_width: assert property ($fell(video.line_sync) |-> hcnt inside {[9'h007:9'h0FF]})
      else $error("line sync width out of range");
   a_back_porch: assert property ($rose(video.active_data_valid) |-> hcnt >= 9'h007)
      else $error("data valid too soon after line sync");
   a_front_porch: assert property ($rose(video.line_sync) |-> fcnt >= 8'h0F)
      else $error("line sync too soon after data valid");
   a_frame_on_line: assert property ($changed(video.frame_sync) |-> $rose(video.line_sync))
      else $error("frame sync edge off a line start");
   a_first_active: assert property ($rose(video.active_data_valid) |-> lcnt >= 8'h02)
      else $error("active line too soon after frame sync");
   a_front_lines: assert property ($rose(video.frame_sync) |-> vcnt >= 8'h01)
      else $error("frame sync too soon after last active line");
   a_vert_blank: assert property ($rose(video.active_data_valid) && vcnt > 8'h01 |-> vcnt >= 8'h0D)
      else $error("vertical blanking too short");
   a_cfg_hold: assert property (cfg.valid && !cfg_ready |=> cfg.valid && $stable(cfg))
      else $error("config word dropped before ready");
   a_cfg_drop: assert property (cfg.valid && cfg_ready |=> !cfg.valid)
      else $error("config word not released after ready");
   a_cfg_range: assert property (cfg.valid |-> cfg.addr == 8'h23 && cfg.data <= 8'h0F)
      else $error("config word address or delay out of range");
   a_launch_edge: assert property ($changed(video) |-> $changed(pclk))
      else $error("video changed away from a pclk edge");
   c_active: cover property ($rose(video.active_data_valid));
   c_cfg: cover property (cfg.valid && cfg_ready);
   c_frame: cover property ($rose(video.frame_sync));
endmodule
bind pvt_video_source pvt_video_source_properties u_props (
   .sys_clk(sys_clk), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
   .pclk(pclk), .video(video), .cfg(cfg), .cfg_ready(cfg_ready)
);
`default_nettype wire

// ---- test/pvt_device_model.sv ----
// behavioural display device: delay setting, configuration port and pixel capture
`timescale 1ns/100ps
`default_nettype none
module pvt_device_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic pclk,
   input wire pvt_pkg::pvt_video_type video,
   input wire pvt_pkg::pvt_cfg_type cfg,
   input wire logic capture_falling,
   input wire logic [3:0] ready_wait,
   output logic cfg_ready,
   output logic [7:0] frame_sync_line_delay,
   output logic [15:0] line_pixels,
   output logic [15:0] line_len,
   output logic [23:0] last_pixel,
   output logic [15:0] frames
);
   logic pclk_q, ls_q, fs_q;
   logic [15:0] pcnt, dcnt;
   logic [3:0] wcnt;
   // sampling edge chosen by software, rising after reset
   wire logic cap = (pclk != pclk_q) && (pclk == !capture_falling);
   // a slow device holds ready back for ready_wait cycles
   assign cfg_ready = cfg.valid && wcnt == ready_wait;
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         {pclk_q, ls_q, fs_q, pcnt, dcnt, wcnt} <= '0;
         frame_sync_line_delay <= 8'h05;
         {line_pixels, line_len, last_pixel, frames} <= '0;
      end else begin
         pclk_q <= pclk;
         wcnt <= (cfg.valid && !cfg_ready) ? wcnt + 4'h1 : 4'h0;
         if (cfg_ready && cfg.addr == 8'h23)
            frame_sync_line_delay <= cfg.data;
         if (cap) begin
            ls_q <= video.line_sync;
            fs_q <= video.frame_sync;
            if (video.frame_sync && !fs_q)
               frames <= frames + 16'h0001;
            if (video.line_sync && !ls_q) begin
               line_len <= pcnt;
               pcnt <= 16'h0001;
               dcnt <= 16'h0000;
               if (dcnt != 16'h0000)
                  line_pixels <= dcnt;
            end else begin
               pcnt <= pcnt + 16'h0001;
               if (video.active_data_valid) begin
                  dcnt <= dcnt + 16'h0001;
                  last_pixel <= video.pixel_bus;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/pvt_video_source_tb.sv ----
// self-checking bench of the video source with a device model on its far side
`timescale 1ns/100ps
`default_nettype none
module pvt_video_source_tb;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   logic capture_falling = 1'b0;
   logic [3:0] ready_wait = 4'h0;
   logic [31:0] hrdata, rd_q, rd;
   logic hreadyout, hresp, pclk, cfg_ready, hr_q;
   pvt_pkg::pvt_video_type video;
   pvt_pkg::pvt_cfg_type cfg;
   logic [7:0] fsld, v;
   logic [15:0] line_pixels, line_len, frames;
   logic [23:0] last_pixel, color;
   logic [7:0] ra[8] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
   logic [31:0] rv[8] = '{32'h0, 32'h01401008, 32'h00040802, 32'h000200F0, 32'h11, 32'h5,
      32'h0, 32'h0};
   int error_cnt = 0;
   int checks = 0;
   int act;
   always #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      rd_q <= hrdata;
      hr_q <= hreadyout;
   end
   pvt_video_source uut (
      .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pclk(pclk), .video(video), .cfg(cfg),
      .cfg_ready(cfg_ready)
   );
   pvt_device_model dev (
      .sys_clk(sys_clk), .resetn(resetn), .pclk(pclk), .video(video), .cfg(cfg),
      .capture_falling(capture_falling), .ready_wait(ready_wait), .cfg_ready(cfg_ready),
      .frame_sync_line_delay(fsld), .line_pixels(line_pixels), .line_len(line_len),
      .last_pixel(last_pixel), .frames(frames)
   );
   // ------------------------------------------------------------
   // bus cycles, comparison and expectations
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // hr_q and rd_q hold what the bus showed just before the edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      #1;
      {hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'b10, w};
      do begin @(posedge sys_clk); #1; end while (hr_q !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      do begin @(posedge sys_clk); #1; end while (hr_q !== 1'b1);
      rd = rd_q;
   endtask
   function automatic logic [31:0] exp_line(input int div, input int lr);
      int k = pvt_pkg::SYS_CLK_KHZ / (2 * div);
      return 32'((k + lr - 1) / lr);
   endfunction
   task automatic wrap_up;
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      $display("ERROR %0t: watchdog expired", $time);
      wrap_up();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(95496));
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      foreach (ra[i]) begin
         bus(1'b0, ra[i], 32'h0);
         chk(rd, rv[i]);
      end
      chk(32'(fsld), 32'h5);
      // reset line: ceil(2500/17) pclks cannot hold 320 active pixels
      bus(1'b1, 8'h00, 32'h1);
      repeat (40) @(posedge sys_clk);
      bus(1'b0, 8'h04, 32'h0);
      chk(32'(rd[1:0]), 32'h2);
      chk(32'(pclk), 32'h0);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h0C, 32'h00040801);
      // delay bounds with vfp 4, vbp 8: 2..6
      for (int i = 0; i < 8; i++) begin
         v = (i < 4) ? 8'(i * 5 + 1) : 8'($urandom_range(15));
         bus(1'b1, 8'h18, {24'h0, v});
         bus(1'b0, 8'h04, 32'h0);
         chk(32'(rd[2]), 32'(v < 8'(6 - 4) || v > 8'(8 - 2)));
      end
      bus(1'b1, 8'h18, 32'h7);
      bus(1'b1, 8'h00, 32'h4);
      repeat (10) @(posedge sys_clk);
      chk(32'(fsld), 32'h5);
      ready_wait <= 4'h3;
      bus(1'b1, 8'h18, 32'h6);
      bus(1'b1, 8'h00, 32'h4);
      while (fsld !== 8'h06) @(posedge sys_clk);
      chk(32'(fsld), 32'h6);
      for (int e = 0; e < 2; e++) begin
         act = $urandom_range(23, 4);
         color = 24'($urandom);
         capture_falling <= e[0];
         bus(1'b1, 8'h08, {act[15:0], 16'h0804});
         bus(1'b1, 8'h10, {12'h0, 4'(e + 1), 16'h4});
         bus(1'b1, 8'h14, 32'(130 >> e));
         bus(1'b1, 8'h1C, {8'h0, color});
         bus(1'b1, 8'h00, {30'h0, e[0], 1'b1});
         v = 8'(frames + 16'h2);
         while (8'(frames) !== v) @(posedge sys_clk);
         bus(1'b0, 8'h04, 32'h0);
         chk(32'(rd[0]), 32'h1);
         chk(32'(line_len), exp_line(e + 1, 130 >> e));
         chk(32'(line_pixels), 32'(act));
         chk(32'(last_pixel), 32'(color));
         bus(1'b1, 8'h00, {30'h0, e[0], 1'b0});
         do bus(1'b0, 8'h04, 32'h0); while (rd[0] !== 1'b0);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
